// ===== bit_processor_branch_unit.sv
// Bit processor and program flow execution unit of the 8-bit core
`timescale 1ns/100ps
`default_nettype none
module bit_processor_branch_unit
    import bit_branch_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Decoded instruction from fetch
    input wire logic instr_valid,
    input wire instr_s instr,
    output logic instr_ready,
    output logic instr_done,
    // Core operands
    input wire logic [7:0] acc,
    input wire logic [15:0] data_pointer,
    // Program counter update
    output logic pc_load,
    output logic [15:0] pc_target,
    output logic int_return_done,
    // Internal data memory, read data valid one clock after rd
    output mem_req_s mem_req,
    input wire logic [7:0] mem_rdata,
    // State seen by the core
    output logic [7:0] program_status_word,
    output logic carry,
    output logic [7:0] stack_pointer
);
    typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_EXEC, ST_PUSH_HI, ST_POP_LO, ST_POP_FIN, ST_WAIT} state_e;

    state_e state_r;
    instr_s instr_r;
    logic [7:0] byte_addr_r, status_r, stack_ptr_r;
    logic sfr_r, status_hit_r, take_r;
    logic [15:0] pc_target_r, target;
    logic accept, mc_last, bit_v, wr_en, c_en, c_val, take, is_call, is_return, nxt_sfr;
    logic [7:0] status_view, opd, wr_data, cmp_a, cmp_b, nxt_byte_addr;
    logic [2:0] bit_idx;

    assign instr_ready = (state_r == ST_IDLE);
    assign accept = instr_valid && instr_ready;
    assign is_call = instr_r.op inside {OP_LONG_CALL, OP_BLOCK_CALL};
    assign is_return = instr_r.op inside {OP_SUB_RETURN, OP_INT_RETURN};

    machine_cycle_timer u_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(accept),
        .two_cycles(two_mc(instr.op)),
        .busy(),
        .last(mc_last)
    );

    always_comb begin
        if (is_bit_op(instr.op)) begin
            nxt_byte_addr = bit_byte_addr(instr.addr);
            nxt_sfr = instr.addr[7];
        end else begin
            nxt_byte_addr = instr.addr;
            nxt_sfr = !instr.ind && instr.addr[7];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            instr_r <= '0;
            byte_addr_r <= 8'h00;
            sfr_r <= 1'b0;
            status_hit_r <= 1'b0;
        end else if (accept) begin
            instr_r <= instr;
            byte_addr_r <= nxt_byte_addr;
            sfr_r <= nxt_sfr;
            status_hit_r <= nxt_sfr && (nxt_byte_addr == STATUS_WORD_ADDR);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        state_r <= needs_operand(instr.op, instr.cmp_src) ? ST_READ : ST_EXEC;
                    end
                end
                ST_READ: state_r <= ST_EXEC;
                ST_EXEC: begin
                    if (is_call) begin
                        state_r <= ST_PUSH_HI;
                    end else if (is_return) begin
                        state_r <= ST_POP_LO;
                    end else begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_PUSH_HI: state_r <= ST_WAIT;
                ST_POP_LO: state_r <= ST_POP_FIN;
                ST_POP_FIN: state_r <= ST_WAIT;
                default: begin
                    if (mc_last) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // parity follows the accumulator, so it is built on read rather than stored
    assign status_view = {status_r[7:1], ^acc};
    assign opd = status_hit_r ? status_view : mem_rdata;
    assign bit_idx = instr_r.addr[2:0];
    assign bit_v = opd[bit_idx];
    assign cmp_a = (instr_r.cmp_src == CMP_MEM_IMM) ? opd : acc;
    assign cmp_b = (instr_r.cmp_src == CMP_ACC_MEM) ? opd : instr_r.imm;

    always_comb begin
        wr_en = 1'b0;
        wr_data = opd;
        c_en = 1'b0;
        c_val = status_r[CARRY_POS];
        take = 1'b0;
        target = rel_target(instr_r.next_pc, instr_r.rel);
        case (instr_r.op)
            OP_MOVE_BIT_TO_C: begin c_en = 1'b1; c_val = bit_v; end
            OP_CLEAR_C: begin c_en = 1'b1; c_val = 1'b0; end
            OP_SET_C: begin c_en = 1'b1; c_val = 1'b1; end
            OP_COMPLEMENT_C: begin c_en = 1'b1; c_val = !status_r[CARRY_POS]; end
            OP_AND_BIT: begin c_en = 1'b1; c_val = status_r[CARRY_POS] & bit_v; end
            OP_AND_NOT_BIT: begin c_en = 1'b1; c_val = status_r[CARRY_POS] & !bit_v; end
            OP_OR_BIT: begin c_en = 1'b1; c_val = status_r[CARRY_POS] | bit_v; end
            OP_OR_NOT_BIT: begin c_en = 1'b1; c_val = status_r[CARRY_POS] | !bit_v; end
            OP_MOVE_C_TO_BIT: begin wr_en = 1'b1; wr_data = put_bit(opd, bit_idx, status_r[CARRY_POS]); end
            OP_CLEAR_BIT: begin wr_en = 1'b1; wr_data = put_bit(opd, bit_idx, 1'b0); end
            OP_SET_BIT: begin wr_en = 1'b1; wr_data = put_bit(opd, bit_idx, 1'b1); end
            OP_COMPLEMENT_BIT: begin wr_en = 1'b1; wr_data = put_bit(opd, bit_idx, !bit_v); end
            OP_BRANCH_CARRY: take = status_r[CARRY_POS];
            OP_BRANCH_NO_CARRY: take = !status_r[CARRY_POS];
            OP_BRANCH_BIT_SET: take = bit_v;
            OP_BRANCH_BIT_CLEAR: take = !bit_v;
            OP_BRANCH_TEST_CLEAR: begin take = bit_v; wr_en = bit_v; wr_data = put_bit(opd, bit_idx, 1'b0); end
            OP_SHORT_JUMP: take = 1'b1;
            OP_LONG_JUMP, OP_LONG_CALL: begin take = 1'b1; target = {instr_r.hi, instr_r.imm}; end
            OP_BLOCK_JUMP, OP_BLOCK_CALL: begin
                take = 1'b1;
                target = {instr_r.next_pc[15:BLOCK_BITS], instr_r.opcode[7:BLOCK_FIELD_POS], instr_r.imm};
            end
            OP_INDEXED_JUMP: begin take = 1'b1; target = data_pointer + {8'h00, acc}; end
            OP_SUB_RETURN, OP_INT_RETURN: take = 1'b1;
            OP_BRANCH_ACC_ZERO: take = (acc == 8'h00);
            OP_BRANCH_ACC_NONZERO: take = (acc != 8'h00);
            OP_DEC_BRANCH: begin wr_en = 1'b1; wr_data = opd - 8'h01; take = (opd != 8'h01); end
            OP_CMP_BRANCH: begin take = (cmp_a != cmp_b); c_en = 1'b1; c_val = (cmp_a < cmp_b); end
            default: take = 1'b0;
        endcase
    end

    // carry lives in the status word
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= STATUS_WORD_RESET;
        end else if (state_r == ST_EXEC) begin
            if (wr_en && status_hit_r) begin
                status_r <= wr_data;
            end else if (c_en) begin
                status_r[CARRY_POS] <= c_val;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stack_ptr_r <= STACK_PTR_RESET;
        end else if ((state_r == ST_EXEC && is_call) || state_r == ST_PUSH_HI) begin
            stack_ptr_r <= stack_ptr_r + 8'h01;
        end else if ((state_r == ST_EXEC && is_return) || state_r == ST_POP_LO) begin
            stack_ptr_r <= stack_ptr_r - 8'h01;
        end
    end

    // popped bytes form the resume address
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pc_target_r <= 16'h0000;
            take_r <= 1'b0;
        end else if (accept) begin
            take_r <= 1'b0;
        end else if (state_r == ST_EXEC) begin
            take_r <= take;
            pc_target_r <= target;
        end else if (state_r == ST_POP_LO) begin
            pc_target_r[15:8] <= mem_rdata;
        end else if (state_r == ST_POP_FIN) begin
            pc_target_r[7:0] <= mem_rdata;
        end
    end

    // push low then high, pop high then low
    always_comb begin
        mem_req = '0;
        case (state_r)
            ST_READ: begin
                mem_req.rd = !status_hit_r;
                mem_req.sfr = sfr_r;
                mem_req.addr = byte_addr_r;
            end
            ST_EXEC: begin
                if (is_call) begin
                    mem_req.wr = 1'b1;
                    mem_req.addr = stack_ptr_r + 8'h01;
                    mem_req.wdata = instr_r.next_pc[7:0];
                end else if (is_return) begin
                    mem_req.rd = 1'b1;
                    mem_req.addr = stack_ptr_r;
                end else if (wr_en && !status_hit_r) begin
                    mem_req.wr = 1'b1;
                    mem_req.sfr = sfr_r;
                    mem_req.addr = byte_addr_r;
                    mem_req.wdata = wr_data;
                end
            end
            ST_PUSH_HI: begin
                mem_req.wr = 1'b1;
                mem_req.addr = stack_ptr_r + 8'h01;
                mem_req.wdata = instr_r.next_pc[15:8];
            end
            ST_POP_LO: begin
                mem_req.rd = 1'b1;
                mem_req.addr = stack_ptr_r;
            end
            default: mem_req = '0;
        endcase
    end

    // PC changes at the end of the instruction only
    assign instr_done = mc_last;
    assign pc_load = mc_last && take_r;
    assign pc_target = pc_target_r;
    assign int_return_done = mc_last && (instr_r.op == OP_INT_RETURN);
    assign program_status_word = status_view;
    assign carry = status_r[CARRY_POS];
    assign stack_pointer = stack_ptr_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    chk_ram_bit_map: assert property (
        (state_r == ST_READ && is_bit_op(instr_r.op) && !instr_r.addr[7])
        |-> mem_req.rd && !mem_req.sfr && mem_req.addr == RAM_BIT_BYTE_BASE + {4'h0, instr_r.addr[6:3]})
        else $error("low bit address mapped to wrong RAM byte");
    chk_single_line: assert property (
        (state_r == ST_EXEC && instr_r.op == OP_MOVE_C_TO_BIT && !status_hit_r)
        |-> mem_req.wr && $onehot0(mem_req.wdata ^ mem_rdata) && mem_req.wdata[bit_idx] == carry)
        else $error("bit write disturbed other lines");
    chk_and_carry: assert property (
        (state_r == ST_READ && instr_r.op == OP_AND_NOT_BIT && !status_hit_r)
        ##1 (mem_rdata[bit_idx] == 1'b1) |=> !carry)
        else $error("AND with complement of one left carry set");
    chk_test_clear: assert property (
        (state_r == ST_EXEC && instr_r.op == OP_BRANCH_TEST_CLEAR && bit_v && !status_hit_r)
        |-> mem_req.wr && !mem_req.wdata[bit_idx] ##[1:23] pc_load)
        else $error("test-and-clear did not clear and jump");
    chk_rel_reach: assert property (
        (pc_load && instr_r.op inside {OP_SHORT_JUMP, OP_BRANCH_CARRY, OP_DEC_BRANCH, OP_CMP_BRANCH})
        |-> pc_target == instr_r.next_pc + {{8{instr_r.rel[7]}}, instr_r.rel})
        else $error("relative target wrong");
    chk_block_keep: assert property (
        (pc_load && instr_r.op inside {OP_BLOCK_JUMP, OP_BLOCK_CALL})
        |-> pc_target[15:11] == instr_r.next_pc[15:11] && pc_target[7:0] == instr_r.imm)
        else $error("block jump left its 2K block");
    chk_one_cycle: assert property (
        (accept && !two_mc(instr.op)) |-> !instr_done [*8] ##1 !instr_done [*3] ##1 instr_done)
        else $error("one machine cycle instruction not twelve clocks");
    chk_two_cycle: assert property (
        (accept && two_mc(instr.op)) |-> ##11 !instr_done ##12 instr_done ##1 instr_ready)
        else $error("two machine cycle instruction not twenty-four clocks");
    chk_push_order: assert property (
        (state_r == ST_EXEC && is_call)
        |-> mem_req.wdata == instr_r.next_pc[7:0] ##1 mem_req.wr && mem_req.wdata == instr_r.next_pc[15:8]
            && mem_req.addr == $past(stack_ptr_r) + 8'h02)
        else $error("call push order or pointer wrong");
    chk_cmp_carry: assert property (
        (state_r == ST_EXEC && instr_r.op == OP_CMP_BRANCH) |=> carry == ($past(cmp_a) < $past(cmp_b)))
        else $error("compare carry wrong");
    chk_interrupt_return_end: assert property (
        int_return_done |-> pc_load && instr_done)
        else $error("interrupt return end without PC load");

endmodule : bit_processor_branch_unit
`default_nettype wire

// ===== bit_branch_pkg.sv
// Shared types, constants and helpers of the bit processor and branch unit
package bit_branch_pkg;

    // Machine cycle: six states of two oscillator periods each
    localparam int CLKS_PER_STATE = 2;
    localparam int STATES_PER_MC = 6;
    localparam int CLKS_PER_MC = CLKS_PER_STATE * STATES_PER_MC;
    localparam logic [4:0] MC1_LAST = 5'(CLKS_PER_MC - 2);
    localparam logic [4:0] MC2_LAST = 5'(2 * CLKS_PER_MC - 2);

    // Bit and byte address map
    localparam logic [7:0] SFR_BIT_BASE = 8'h80;
    localparam logic [7:0] RAM_BIT_BYTE_BASE = 8'h20;
    localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
    localparam logic [7:0] STACK_PTR_RESET = 8'h07;
    localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
    localparam int CARRY_POS = 7;
    localparam int PARITY_POS = 0;
    localparam int BLOCK_FIELD_POS = 5;
    localparam int BLOCK_BITS = 11;

    typedef enum logic [4:0] {
        OP_NO_OPERATION, OP_MOVE_BIT_TO_C, OP_MOVE_C_TO_BIT, OP_CLEAR_C, OP_CLEAR_BIT,
        OP_SET_C, OP_SET_BIT, OP_COMPLEMENT_C, OP_COMPLEMENT_BIT, OP_AND_BIT, OP_AND_NOT_BIT,
        OP_OR_BIT, OP_OR_NOT_BIT, OP_BRANCH_CARRY, OP_BRANCH_NO_CARRY, OP_BRANCH_BIT_SET,
        OP_BRANCH_BIT_CLEAR, OP_BRANCH_TEST_CLEAR, OP_SHORT_JUMP, OP_LONG_JUMP, OP_BLOCK_JUMP,
        OP_INDEXED_JUMP, OP_LONG_CALL, OP_BLOCK_CALL, OP_SUB_RETURN, OP_INT_RETURN,
        OP_BRANCH_ACC_ZERO, OP_BRANCH_ACC_NONZERO, OP_DEC_BRANCH, OP_CMP_BRANCH
    } op_e;

    typedef enum logic [1:0] {CMP_ACC_IMM, CMP_ACC_MEM, CMP_MEM_IMM} cmp_src_e;

    typedef struct packed {
        op_e op;
        logic [7:0] opcode;
        logic [7:0] addr;
        logic ind;
        logic [7:0] imm;
        logic [7:0] hi;
        logic [7:0] rel;
        cmp_src_e cmp_src;
        logic [15:0] next_pc;
    } instr_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic sfr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_s;

    function automatic logic is_bit_op(input op_e op);
        return op inside {OP_MOVE_BIT_TO_C, OP_MOVE_C_TO_BIT, OP_CLEAR_BIT, OP_SET_BIT,
            OP_COMPLEMENT_BIT, OP_AND_BIT, OP_AND_NOT_BIT, OP_OR_BIT, OP_OR_NOT_BIT,
            OP_BRANCH_BIT_SET, OP_BRANCH_BIT_CLEAR, OP_BRANCH_TEST_CLEAR};
    endfunction : is_bit_op

    function automatic logic needs_operand(input op_e op, input cmp_src_e src);
        return is_bit_op(op) || op == OP_DEC_BRANCH || (op == OP_CMP_BRANCH && src != CMP_ACC_IMM);
    endfunction : needs_operand

    function automatic logic two_mc(input op_e op);
        return !(op inside {OP_NO_OPERATION, OP_MOVE_BIT_TO_C, OP_CLEAR_C, OP_CLEAR_BIT,
            OP_SET_C, OP_SET_BIT, OP_COMPLEMENT_C, OP_COMPLEMENT_BIT});
    endfunction : two_mc

    // Low 128 bit addresses live in 16 RAM bytes, the upper half in SFR bytes on multiples of 8
    function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
        if (bit_addr[7]) begin
            return {bit_addr[7:3], 3'b000};
        end
        return RAM_BIT_BYTE_BASE + {4'h0, bit_addr[6:3]};
    endfunction : bit_byte_addr

    function automatic logic [15:0] rel_target(input logic [15:0] base, input logic [7:0] rel);
        return base + {{8{rel[7]}}, rel};
    endfunction : rel_target

    function automatic logic [7:0] put_bit(input logic [7:0] data, input logic [2:0] idx, input logic val);
        logic [7:0] res;
        res = data;
        res[idx] = val;
        return res;
    endfunction : put_bit

endpackage : bit_branch_pkg

// ===== machine_cycle_timer.sv
// Counts the one or two machine cycles that an instruction occupies
`timescale 1ns/100ps
`default_nettype none
module machine_cycle_timer
    import bit_branch_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic start,
    input wire logic two_cycles,
    // Status
    output logic busy,
    output logic last
);
    logic [4:0] cnt_r;
    logic [4:0] limit_r;
    logic busy_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 5'h0;
            limit_r <= 5'h0;
            busy_r <= 1'b0;
        end else if (start) begin
            cnt_r <= 5'h0;
            limit_r <= two_cycles ? MC2_LAST : MC1_LAST;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            if (cnt_r == limit_r) begin
                busy_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r + 5'h1;
            end
        end
    end

    assign busy = busy_r;
    assign last = busy_r && (cnt_r == limit_r);
endmodule : machine_cycle_timer
`default_nettype wire

// ===== data_memory_model.sv
// Behavioural internal data memory that answers the unit's memory port
`timescale 1ns/100ps
`default_nettype none
module data_memory_model
    import bit_branch_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Memory port
    input wire mem_req_s mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [256];
    logic [7:0] sfr [128];

    initial begin
        mem_rdata = 8'h00;
    end

    // Read data stands one clock only; then the inverse shows so stale data cannot pass
    always @(posedge clk_sys) begin
        if (mem_req.rd) begin
            mem_rdata <= mem_req.sfr ? sfr[mem_req.addr[6:0]] : ram[mem_req.addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_req.wr && mem_req.sfr) begin
            sfr[mem_req.addr[6:0]] <= mem_req.wdata;
        end else if (mem_req.wr) begin
            ram[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule : data_memory_model
`default_nettype wire

// ===== bit_processor_branch_unit_bench.sv
// Self-checking bench of the bit processor and branch unit with its memory model
`timescale 1ns/100ps
`default_nettype none
module bit_processor_branch_unit_bench import bit_branch_pkg::*;;
    typedef struct packed {
        instr_s i;
        logic [7:0] acc;
        logic ld;
        logic [15:0] tgt;
        logic cy;
    } row_s;
    logic clk_sys, sys_rst, instr_valid, instr_ready, instr_done, pc_load, int_return_done, carry;
    instr_s instr;
    logic [7:0] acc, mem_rdata, program_status_word, stack_pointer;
    logic [15:0] data_pointer, pc_target;
    mem_req_s mem_req;
    row_s rows[$];
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    logic got_ld, got_ird;
    logic [15:0] got_tgt;

    bit_processor_branch_unit bit_processor_branch_unit_i (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done),
        .acc(acc), .data_pointer(data_pointer), .pc_load(pc_load), .pc_target(pc_target),
        .int_return_done(int_return_done), .mem_req(mem_req), .mem_rdata(mem_rdata),
        .program_status_word(program_status_word), .carry(carry), .stack_pointer(stack_pointer));
    data_memory_model data_memory_model_i (.clk_sys(clk_sys), .mem_req(mem_req), .mem_rdata(mem_rdata));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            $display("ERROR timeout expected finish seen hang");
            print_verdict();
        end
    end

    // Compare source rides in hi[1:0], which compare rows never use otherwise
    function automatic instr_s mk(input op_e op, input logic [7:0] ad, input logic [7:0] im, input logic [7:0] hi,
            input logic [7:0] rel, input logic [15:0] npc);
        return instr_s'{op, hi, ad, 1'b0, im, hi, rel, cmp_src_e'(hi[1:0]), npc};
    endfunction : mk

    task automatic add(input op_e op, input logic [7:0] ad, input logic [7:0] im, input logic [7:0] hi,
            input logic [7:0] rel, input logic [15:0] npc, input logic [7:0] a, input logic ld,
            input logic [15:0] tgt, input logic cy);
        rows.push_back(row_s'{mk(op, ad, im, hi, rel, npc), a, ld, tgt, cy});
    endtask : add

    // Entered 5 ns after a rising edge; returns likewise, in the cycle after completion
    task automatic run(input instr_s i, input logic [7:0] a);
        logic one;
        one = i.op inside {OP_NO_OPERATION, OP_MOVE_BIT_TO_C, OP_CLEAR_C, OP_CLEAR_BIT, OP_SET_C,
            OP_SET_BIT, OP_COMPLEMENT_C, OP_COMPLEMENT_BIT};
        instr = i;
        acc = a;
        instr_valid = 1'b1;
        @(negedge clk_sys);
        check("ready", instr_ready, 1'b1);
        @(posedge clk_sys);
        #5;
        instr_valid = 1'b0;
        n = 0;
        while (n < 30) begin
            @(negedge clk_sys);
            n++;
            if (instr_done === 1'b1) begin
                break;
            end
        end
        got_ld = pc_load;
        got_tgt = pc_target;
        got_ird = int_return_done;
        check("cycles", 16'(n), one ? 16'h000B : 16'h0017);
        @(posedge clk_sys);
        #5;
    endtask : run

    initial begin
        sys_rst = 1'b1;
        instr_valid = 1'b0;
        instr = '0;
        acc = 8'h00;
        data_pointer = 16'h12F0;
        data_memory_model_i.ram[8'h20] = 8'hA5;
        data_memory_model_i.ram[8'h21] = 8'h00;
        data_memory_model_i.ram[8'h30] = 8'h01;
        data_memory_model_i.sfr[7'h10] = 8'h5C;
        repeat (4) @(posedge clk_sys);
        #5;
        sys_rst = 1'b0;
        check("stack reset", stack_pointer, 8'h07);
        check("status reset", program_status_word, 8'h00);
        add(OP_NO_OPERATION, '0, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_SET_C, '0, '0, '0, '0, '0, '0, 0, '0, 1);
        add(OP_MOVE_BIT_TO_C, 8'h01, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_COMPLEMENT_C, '0, '0, '0, '0, '0, '0, 0, '0, 1);
        add(OP_AND_BIT, 8'h00, '0, '0, '0, '0, '0, 0, '0, 1);
        add(OP_AND_NOT_BIT, 8'h00, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_OR_NOT_BIT, 8'h01, '0, '0, '0, '0, '0, 0, '0, 1);
        add(OP_CLEAR_C, '0, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_OR_BIT, 8'h02, '0, '0, '0, '0, '0, 0, '0, 1);
        add(OP_MOVE_C_TO_BIT, 8'h91, '0, '0, '0, '0, '0, 0, '0, 1);
        add(OP_BRANCH_CARRY, '0, '0, '0, 8'h80, 16'h1000, '0, 1, 16'h0F80, 1);
        add(OP_BRANCH_NO_CARRY, '0, '0, '0, 8'h10, 16'h1000, '0, 0, '0, 1);
        add(OP_BRANCH_BIT_SET, 8'h05, '0, '0, 8'h7F, 16'h2000, '0, 1, 16'h207F, 1);
        add(OP_BRANCH_BIT_CLEAR, 8'hD0, '0, '0, 8'h02, 16'h0100, 8'h03, 1, 16'h0102, 1);
        add(OP_BRANCH_TEST_CLEAR, 8'h07, '0, '0, 8'hFE, 16'h0300, '0, 1, 16'h02FE, 1);
        add(OP_BRANCH_TEST_CLEAR, 8'h07, '0, '0, 8'hFE, 16'h0300, '0, 0, '0, 1);
        add(OP_SHORT_JUMP, '0, '0, '0, 8'h05, 16'h0400, '0, 1, 16'h0405, 1);
        add(OP_LONG_JUMP, '0, 8'h34, 8'h12, '0, 16'h0803, '0, 1, 16'h1234, 1);
        add(OP_BLOCK_JUMP, '0, 8'h56, 8'hE1, '0, 16'h37FE, '0, 1, 16'h3756, 1);
        add(OP_INDEXED_JUMP, '0, '0, '0, '0, 16'h0900, 8'hFF, 1, 16'h13EF, 1);
        add(OP_BRANCH_ACC_ZERO, '0, '0, '0, 8'h10, 16'h0500, 8'h00, 1, 16'h0510, 1);
        add(OP_BRANCH_ACC_NONZERO, '0, '0, '0, 8'h10, 16'h0500, 8'h00, 0, '0, 1);
        add(OP_CMP_BRANCH, '0, 8'h20, 8'h00, 8'h04, 16'h0600, 8'h10, 1, 16'h0604, 1);
        add(OP_CMP_BRANCH, '0, 8'h20, 8'h00, 8'h04, 16'h0600, 8'h20, 0, '0, 0);
        add(OP_CMP_BRANCH, 8'h30, 8'h80, 8'h02, 8'h04, 16'h0600, '0, 1, 16'h0604, 1);
        add(OP_CMP_BRANCH, 8'h30, '0, 8'h01, 8'h04, 16'h0600, 8'hF0, 1, 16'h0604, 0);
        add(OP_DEC_BRANCH, 8'h30, '0, '0, 8'hFC, 16'h0700, '0, 0, '0, 0);
        add(OP_DEC_BRANCH, 8'h30, '0, '0, 8'hFC, 16'h0700, '0, 1, 16'h06FC, 0);
        add(OP_SET_BIT, 8'h08, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_COMPLEMENT_BIT, 8'h0F, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_CLEAR_BIT, 8'h08, '0, '0, '0, '0, '0, 0, '0, 0);
        add(OP_SET_BIT, 8'hD7, '0, '0, '0, '0, '0, 0, '0, 1);
        foreach (rows[k]) begin
            run(rows[k].i, rows[k].acc);
            check("taken", got_ld, rows[k].ld);
            if (rows[k].ld) begin
                check("target", got_tgt, rows[k].tgt);
            end
            check("carry", carry, rows[k].cy);
        end
        check("cleared flag", data_memory_model_i.ram[8'h20], 8'h25);
        check("port byte", data_memory_model_i.sfr[7'h10], 8'h5E);
        check("counter", data_memory_model_i.ram[8'h30], 8'hFF);
        check("bit byte", data_memory_model_i.ram[8'h21], 8'h80);
        // calls push the return address low byte first
        run(mk(OP_LONG_CALL, '0, 8'h00, 8'h40, '0, 16'h1234), 8'h00);
        check("long call", got_tgt, 16'h4000);
        run(mk(OP_BLOCK_CALL, '0, 8'h10, 8'h20, '0, 16'h4003), 8'h00);
        check("block call", got_tgt, 16'h4110);
        check("push low", data_memory_model_i.ram[8'h08], 8'h34);
        check("push high", data_memory_model_i.ram[8'h09], 8'h12);
        check("push second", data_memory_model_i.ram[8'h0B], 8'h40);
        check("stack grown", stack_pointer, 8'h0B);
        run(mk(OP_SUB_RETURN, '0, '0, '0, '0, 16'h4111), 8'h00);
        check("return", got_tgt, 16'h4003);
        check("plain return", got_ird, 1'b0);
        run(mk(OP_INT_RETURN, '0, '0, '0, '0, 16'h4004), 8'h00);
        check("int return", got_tgt, 16'h1234);
        check("end of int", got_ird, 1'b1);
        check("stack back", stack_pointer, 8'h07);
        // reset in mid-call leaves no jump behind
        instr = mk(OP_LONG_CALL, '0, 8'h00, 8'h40, '0, 16'h1234);
        instr_valid = 1'b1;
        repeat (5) @(posedge clk_sys);
        #5;
        instr_valid = 1'b0;
        sys_rst = 1'b1;
        @(posedge clk_sys);
        #5;
        sys_rst = 1'b0;
        check("stack after reset", stack_pointer, 8'h07);
        check("carry after reset", carry, 1'b0);
        n = 0;
        repeat (30) begin
            @(negedge clk_sys);
            n += int'(pc_load === 1'b1);
        end
        check("stale jump", 16'(n), 16'h0000);
        @(posedge clk_sys);
        #5;
        run(mk(OP_NO_OPERATION, '0, '0, '0, '0, '0), 8'h00);
        print_verdict();
    end
endmodule : bit_processor_branch_unit_bench
`default_nettype wire
